// ---- logic/mpo_limit_sense.sv ----
// one limit sensor channel: polarity and active level
`timescale 1ns/100ps
module mpo_limit_sense (
	input  wire logic core_clk_i,
	input  wire logic rst_i,
	input  wire logic sensor_i,
	input  wire logic polarity_i,
	output logic      active_o
);
	import mpo_pkg::*;

	typedef struct packed {
		logic active;
	} mpo_ls_s;

	mpo_ls_s st_r;
	mpo_ls_s st_nxt;

	// normally open: high means hit; normally closed: low means hit
	always_comb begin
		st_nxt        = st_r;
		st_nxt.active = sensor_i ^ polarity_i;
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign active_o = st_r.active;
endmodule // mpo_limit_sense

// ---- logic/mpo_overload_timer.sv ----
// overload persistence timer counting tenth-second ticks
`timescale 1ns/100ps
module mpo_overload_timer #(
	parameter int TICK = mpo_pkg::TICK_CYCLES
) (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic       overload_i,
	input  wire logic [7:0] limit_i,
	output logic            expired_o
);
	import mpo_pkg::*;

	typedef struct packed {
		logic [23:0] pre;
		logic [7:0]  tenths;
		logic        expired;
	} mpo_olt_s;

	mpo_olt_s st_r;
	mpo_olt_s st_nxt;

	// counter restarts whenever the overload condition drops
	always_comb begin
		st_nxt = st_r;
		if (!overload_i) begin
			st_nxt.pre    = '0;
			st_nxt.tenths = '0;
		end else if (!st_r.expired) begin
			if (st_r.pre == 24'(TICK - 1)) begin
				st_nxt.pre    = '0;
				st_nxt.tenths = st_r.tenths + 8'h01;
			end else begin
				st_nxt.pre = st_r.pre + 24'h000001;
			end
			if (st_nxt.tenths >= limit_i) begin
				st_nxt.expired = 1'b1;
			end
		end
		if (!overload_i) begin
			st_nxt.expired = 1'b0;
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expired_o = st_r.expired;
endmodule // mpo_overload_timer

// ---- logic/mpo_pkg.sv ----
// package of constants and types for motion protection and output ports
package mpo_pkg;
	// register addresses on the plain register port
	localparam logic [3:0] ADDR_OL_TIME   = 4'h0; // overload time, 0.1 s units
	localparam logic [3:0] ADDR_OT_CTRL   = 4'h1; // bit0 stop action, bit1 pol
	localparam logic [3:0] ADDR_OUT_MON   = 4'h2; // output monitor (read)
	localparam logic [3:0] ADDR_OUT_DRIVE = 4'h3; // [3] value, [2:0] port x
	localparam logic [3:0] ADDR_ASSIGN    = 4'h4; // [3] enable, [2:0] port
	localparam logic [3:0] ADDR_IRQ_STAT  = 4'h5; // w1c event bits
	localparam logic [3:0] ADDR_IRQ_MASK  = 4'h6;
	localparam logic [3:0] ADDR_ALARM     = 4'h7; // alarm code; a write clears it
	localparam logic [3:0] ADDR_MOTION    = 4'h8; // motion command
	// overload time limits and default
	localparam logic [7:0] OL_TIME_MIN = 8'h05;
	localparam logic [7:0] OL_TIME_MAX = 8'hFA;
	localparam logic [7:0] OL_TIME_RST = 8'h32;
	localparam logic [7:0] ALARM_OVERLOAD = 8'h30;
	localparam logic [7:0] ALARM_NONE     = 8'h00;
	// tenth-second tick from a 125 MHz clock
	localparam int CLK_HZ        = 125000000;
	localparam int TICK_TENTH_MS = 100;
	localparam int TICK_CYCLES   = CLK_HZ / 1000 * TICK_TENTH_MS;
	// interrupt status bit positions
	localparam int IRQ_OVERLOAD  = 0;
	localparam int IRQ_OT_POS    = 1;
	localparam int IRQ_OT_NEG    = 2;
	localparam int IRQ_W         = 3;
	// motion commands
	typedef enum logic [2:0] {
		MOT_IDLE     = 3'b000,
		MOT_CONT_POS = 3'b001,
		MOT_CONT_NEG = 3'b010,
		MOT_HOME     = 3'b011,
		MOT_STOP     = 3'b100
	} mpo_motion_e;
endpackage

// ---- logic/mpo_protect_top.sv ----
// protection and general output port logic of the motor command block
//
// Added by the designer: the address-and-strobe port and the register offsets.
`timescale 1ns/100ps
// Summary of operation
// - overload time 5..250 tenths of a second, default 50, read and write
// - overload lasting the active time raises alarm code 30h
// - new overload time is only stored; the active time stays at default 50
// - overtravel stop is immediate for action 0, decelerating for 1
// - in overtravel only home seeking or motion away, at start speed
// - limit sensors normally open at polarity 0, normally closed at 1
// - output monitor bit n shows output port n, value 0..255
// - monitor shows raw driver state, never any inversion
// - monitor shows nothing for the port with a function assigned
// - per-port write turns port x off with 0, on with 1
// - per-port write to a function-assigned port is ignored
// - a function output may be assigned to one port 0..7
module mpo_protect_top #(
	parameter int TICK = mpo_pkg::TICK_CYCLES
) (
	input  wire logic       core_clk_i,
	input  wire logic       rst_i,
	input  wire logic [3:0] addr_i,
	input  wire logic [7:0] wdata_i,
	input  wire logic       wr_i,
	input  wire logic       rd_i,
	output logic      [7:0] rdata_o,
	input  wire logic       overload_i,
	input  wire logic       pos_limit_sensor_i,
	input  wire logic       neg_limit_sensor_i,
	input  wire logic       func_signal_i,
	input  wire logic       motion_done_i,
	output logic      [7:0] output_port_drive_o,
	output logic            stop_now_o,
	output logic            stop_decel_o,
	output logic            start_speed_o,
	output logic      [1:0] motion_dir_o,
	output logic            home_seek_o,
	output logic            irq_o
);
	import mpo_pkg::*;

	typedef struct packed {
		// settings; all but ol_active written over the register port
		logic [7:0]  ol_stored;    // last written setting
		logic [7:0]  ol_active;    // setting in force
		logic        stop_action;  // overtravel_stop_action
		logic        polarity;     // limit_sensor_polarity
		// general output ports and the function assignment
		logic [7:0]  port_drive;   // general port levels
		logic        assign_en;
		logic [2:0]  assign_port;
		// interrupt and alarm state
		logic [IRQ_W-1:0] stat;
		logic [IRQ_W-1:0] mask;
		logic [7:0]  alarm;
		// motion supervision
		logic        ot_pos;
		logic        ot_neg;
		mpo_motion_e motion;
		// registered copies of every output
		logic [7:0]  rdata;
		logic [7:0]  out_pins;
		logic        stop_now;
		logic        stop_decel;
		logic        start_speed;
		logic [1:0]  dir;
		logic        home;
		logic        irq;
		// overload flag one cycle back, for edge detection
		logic        ol_prev;
	} mpo_top_s;

	mpo_top_s st_r;
	mpo_top_s st_nxt;

	// limit and overload flags from the helper blocks
	logic pos_hit;
	logic neg_hit;
	logic ol_expired;

	// one sensor channel per travel side
	mpo_limit_sense u_pos_ls (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.sensor_i   (pos_limit_sensor_i),
		.polarity_i (st_r.polarity),
		.active_o   (pos_hit)
	);

	mpo_limit_sense u_neg_ls (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.sensor_i   (neg_limit_sensor_i),
		.polarity_i (st_r.polarity),
		.active_o   (neg_hit)
	);

	mpo_overload_timer #(
		.TICK (TICK)
	) u_ol_timer (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.overload_i (overload_i),
		.limit_i    (st_r.ol_active),
		.expired_o  (ol_expired)
	);

	// register port, overtravel supervision, port drive and interrupts
	always_comb begin
		logic [7:0]       mon;
		logic [IRQ_W-1:0] ev;
		logic             ot_enter_pos;
		logic             ot_enter_neg;
		mon          = '0;
		ev           = '0;
		ot_enter_pos = 1'b0;
		ot_enter_neg = 1'b0;
		st_nxt       = st_r;
		st_nxt.stop_now   = 1'b0;
		st_nxt.stop_decel = 1'b0;
		st_nxt.rdata      = '0;
		st_nxt.ol_prev    = ol_expired;

		// overload alarm on the rising edge of the persistence flag
		// the code stays until software writes the alarm register
		if (ol_expired && !st_r.ol_prev) begin
			st_nxt.alarm       = ALARM_OVERLOAD;
			ev[IRQ_OVERLOAD]   = 1'b1;
		end

		// only the sensor ahead of the current travel counts
		if (pos_hit && st_r.motion == MOT_CONT_POS && !st_r.ot_pos) begin
			ot_enter_pos = 1'b1;
		end
		if (neg_hit && st_r.motion == MOT_CONT_NEG && !st_r.ot_neg) begin
			ot_enter_neg = 1'b1;
		end
		// entry stops the motor and drops the running command
		if (ot_enter_pos || ot_enter_neg) begin
			st_nxt.ot_pos = st_r.ot_pos | ot_enter_pos;
			st_nxt.ot_neg = st_r.ot_neg | ot_enter_neg;
			st_nxt.stop_now   = !st_r.stop_action;
			st_nxt.stop_decel = st_r.stop_action;
			st_nxt.motion     = MOT_IDLE;
			ev[IRQ_OT_POS]    = ot_enter_pos;
			ev[IRQ_OT_NEG]    = ot_enter_neg;
		end

		// escape move leaves the range at start speed, then stops
		if (st_r.ot_pos && !pos_hit && st_r.motion == MOT_CONT_NEG) begin
			st_nxt.ot_pos     = 1'b0;
			st_nxt.motion     = MOT_IDLE;
			st_nxt.stop_decel = 1'b1;
		end
		// and the mirror case at the negative end
		if (st_r.ot_neg && !neg_hit && st_r.motion == MOT_CONT_POS) begin
			st_nxt.ot_neg     = 1'b0;
			st_nxt.motion     = MOT_IDLE;
			st_nxt.stop_decel = 1'b1;
		end
		// a finished home seek clears both overtravel flags
		if (motion_done_i && st_r.motion == MOT_HOME) begin
			st_nxt.motion = MOT_IDLE;
			st_nxt.ot_pos = 1'b0;
			st_nxt.ot_neg = 1'b0;
		end

		// register writes
		if (wr_i) begin
			case (addr_i)
				ADDR_OL_TIME: begin
					// out-of-range settings are dropped, the old value stays
					if (wdata_i >= OL_TIME_MIN && wdata_i <= OL_TIME_MAX) begin
						st_nxt.ol_stored = wdata_i;
					end
				end
				ADDR_OT_CTRL: begin
					// a new polarity applies from the next sensor sample
					st_nxt.stop_action = wdata_i[0];
					st_nxt.polarity    = wdata_i[1];
				end
				ADDR_OUT_DRIVE: begin
					// assigned port keeps following the function signal
					if (!(st_r.assign_en &&
					      st_r.assign_port == wdata_i[2:0])) begin
						st_nxt.port_drive[wdata_i[2:0]] = wdata_i[3];
					end
				end
				ADDR_ASSIGN: begin
					// one function output; a new assignment replaces the old
					st_nxt.assign_en   = wdata_i[3];
					st_nxt.assign_port = wdata_i[2:0];
				end
				ADDR_IRQ_MASK: st_nxt.mask = wdata_i[IRQ_W-1:0];
				ADDR_ALARM: begin
					// an alarm raised in this cycle survives the clear
					if (!ev[IRQ_OVERLOAD]) begin
						st_nxt.alarm = ALARM_NONE;
					end
				end
				ADDR_MOTION: begin
					// while in overtravel only home or an escape move
					case (mpo_motion_e'(wdata_i[2:0]))
						MOT_HOME: st_nxt.motion = MOT_HOME;
						MOT_CONT_POS: begin
							if (!st_nxt.ot_pos) begin
								st_nxt.motion = MOT_CONT_POS;
							end
						end
						MOT_CONT_NEG: begin
							if (!st_nxt.ot_neg) begin
								st_nxt.motion = MOT_CONT_NEG;
							end
						end
						MOT_STOP: begin
							// stop is taken in any state and ramps down
							st_nxt.motion     = MOT_IDLE;
							st_nxt.stop_decel = 1'b1;
						end
						default: st_nxt.motion = st_r.motion;
					endcase
				end
				default: begin
					// read-only and unused offsets take no write
					st_nxt.mask = st_nxt.mask;
				end
			endcase
		end

		// monitor: raw levels, blank for the assigned port
		for (int i = 0; i < 8; i++) begin
			mon[i] = st_r.out_pins[i];
		end
		if (st_r.assign_en) begin
			mon[st_r.assign_port] = 1'b0;
		end

		// register reads, data one cycle later
		if (rd_i) begin
			case (addr_i)
				ADDR_OL_TIME:  st_nxt.rdata = st_r.ol_stored;
				ADDR_OT_CTRL:  st_nxt.rdata = {6'h00, st_r.polarity,
				                               st_r.stop_action};
				ADDR_OUT_MON:  st_nxt.rdata = mon;
				ADDR_ASSIGN:   st_nxt.rdata = {4'h0, st_r.assign_en,
				                               st_r.assign_port};
				ADDR_IRQ_STAT: st_nxt.rdata = {5'h00, st_r.stat};
				ADDR_IRQ_MASK: st_nxt.rdata = {5'h00, st_r.mask};
				ADDR_ALARM:    st_nxt.rdata = st_r.alarm;
				ADDR_MOTION:   st_nxt.rdata = {3'h0, st_r.ot_neg, st_r.ot_pos,
				                               st_r.motion};
				// the write-only port control reads back as zero
				ADDR_OUT_DRIVE: st_nxt.rdata = 8'h00;
				default:       st_nxt.rdata = 8'h00;
			endcase
		end

		// sticky status: a new event wins over the same-cycle clear
		if (wr_i && addr_i == ADDR_IRQ_STAT) begin
			st_nxt.stat = st_r.stat & ~wdata_i[IRQ_W-1:0];
		end
		st_nxt.stat = st_nxt.stat | ev;
		st_nxt.irq  = |(st_nxt.stat & st_nxt.mask);

		// pin levels: function signal replaces the assigned port
		st_nxt.out_pins = st_nxt.port_drive;
		if (st_nxt.assign_en) begin
			st_nxt.out_pins[st_nxt.assign_port] = func_signal_i;
		end

		// start speed holds while either overtravel flag is set
		st_nxt.start_speed = st_nxt.ot_pos | st_nxt.ot_neg;

		// direction and home lines leave through flops like every output
		st_nxt.dir  = {st_nxt.motion == MOT_CONT_NEG,
		               st_nxt.motion == MOT_CONT_POS};
		st_nxt.home = st_nxt.motion == MOT_HOME;

		// one stop kind per event; an immediate stop outranks a ramp
		if (st_nxt.stop_now) begin
			st_nxt.stop_decel = 1'b0;
		end
	end

	// power-on reset loads default 50 into both the stored and the active setting
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			st_r           <= '0;
			st_r.ol_stored <= OL_TIME_RST;
			st_r.ol_active <= OL_TIME_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	// every output is a plain copy of a state flop
	assign rdata_o             = st_r.rdata;
	assign output_port_drive_o = st_r.out_pins;
	assign stop_now_o          = st_r.stop_now;
	assign stop_decel_o        = st_r.stop_decel;
	assign start_speed_o       = st_r.start_speed;
	assign motion_dir_o        = st_r.dir;
	assign home_seek_o         = st_r.home;
	assign irq_o               = st_r.irq;
endmodule // mpo_protect_top

// ---- tb/mpo_limit_model.sv ----
// limit sensor pair with selectable contact type
`timescale 1ns/100ps
module mpo_limit_model (
	input  wire logic pol_i,
	input  wire logic hit_pos_i,
	input  wire logic hit_neg_i,
	output logic      pos_raw_o,
	output logic      neg_raw_o
);
	// a closed contact opens at the limit, so the level flips
	assign pos_raw_o = hit_pos_i ^ pol_i;
	assign neg_raw_o = hit_neg_i ^ pol_i;
endmodule // mpo_limit_model

// ---- tb/mpo_protect_properties.sv ----
// checker for stop pulses, motion lines and the general port registers
`timescale 1ns/100ps
module mpo_protect_properties (
	input wire logic       core_clk_i,
	input wire logic       rst_i,
	input wire logic [3:0] addr_i,
	input wire logic [7:0] wdata_i,
	input wire logic       wr_i,
	input wire logic       rd_i,
	input wire logic [7:0] rdata_o,
	input wire logic [7:0] output_port_drive_o,
	input wire logic       stop_now_o,
	input wire logic       stop_decel_o,
	input wire logic [1:0] motion_dir_o
);
	import mpo_pkg::*;
	logic       asg_en_r;
	logic [2:0] asg_port_r;
	logic [7:0] asg_mask;
	// shadow of the function port; a new assignment replaces the old one
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			asg_en_r   <= 1'h0;
			asg_port_r <= 3'h0;
		end else if (wr_i && addr_i == ADDR_ASSIGN) begin
			asg_en_r   <= wdata_i[3];
			asg_port_r <= wdata_i[2:0];
		end
	end
	assign asg_mask = asg_en_r ? (8'h01 << asg_port_r) : 8'h00;
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	chk_rd_idle: assert property (
		!rd_i |=> rdata_o == 8'h00) else $error("stale read data");
	chk_stop_excl: assert property (
		!(stop_now_o && stop_decel_o)) else $error("two stop kinds");
	chk_dir_excl: assert property (
		motion_dir_o != 2'h3) else $error("both directions");
	chk_stop_dir: assert property (
		stop_now_o |-> motion_dir_o == 2'h0 [*2])
		else $error("motion after stop");
	chk_now_pulse: assert property (
		stop_now_o |=> !stop_now_o) else $error("stop pulse too long");
	chk_decel_pulse: assert property (
		$rose(stop_decel_o) |=> $fell(stop_decel_o))
		else $error("decel pulse too long");
	chk_port_write: assert property (
		wr_i && addr_i == ADDR_OUT_DRIVE &&
		!(asg_en_r && asg_port_r == wdata_i[2:0])
		|=> output_port_drive_o[$past(wdata_i[2:0])] == $past(wdata_i[3]))
		else $error("port write lost");
	chk_mon_read: assert property (
		rd_i && addr_i == ADDR_OUT_MON |=>
		rdata_o == ($past(output_port_drive_o) & ~$past(asg_mask)))
		else $error("monitor value wrong");
endmodule // mpo_protect_properties

bind mpo_protect_top mpo_protect_properties u_chk (.core_clk_i, .rst_i,
	.addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .output_port_drive_o,
	.stop_now_o, .stop_decel_o, .motion_dir_o);

// ---- tb/tb_mpo_protect_top.sv ----
// testbench for protection and general output port logic
`timescale 1ns/100ps
module tb_mpo_protect_top;
	import mpo_pkg::*;
	logic       core_clk_i, rst_i, wr_i, rd_i, overload_i, rd_d;
	logic       func_signal_i, motion_done_i, pol, hit, pos_raw, neg_raw;
	logic       stop_now_o, stop_decel_o, start_speed_o, home_seek_o, irq_o;
	logic [3:0] addr_i;
	logic [1:0] motion_dir_o;
	logic [7:0] wdata_i, rdata_o, output_port_drive_o, mir;
	logic [7:0] exp_q[$];
	logic [7:0] olv[4] = '{8'hFA, 8'hFB, 8'h04, 8'h05};
	logic [7:0] ole[4] = '{8'hFA, 8'hFA, 8'hFA, 8'h05};
	int         error_cnt, cmp_count, n;

	mpo_protect_top #(.TICK(4)) uut (.core_clk_i, .rst_i, .addr_i,
		.wdata_i, .wr_i, .rd_i, .rdata_o, .overload_i,
		.pos_limit_sensor_i(pos_raw), .neg_limit_sensor_i(neg_raw),
		.func_signal_i, .motion_done_i, .output_port_drive_o, .stop_now_o,
		.stop_decel_o, .start_speed_o, .motion_dir_o, .home_seek_o, .irq_o);
	mpo_limit_model u_lim (.pol_i(pol), .hit_pos_i(hit), .hit_neg_i(1'h0),
		.pos_raw_o(pos_raw), .neg_raw_o(neg_raw));

	// 125 MHz clock
	initial begin
		core_clk_i = 1'h0;
		forever #4 core_clk_i = ~core_clk_i;
	end

	task automatic chk8(string nm, logic [7:0] e, logic [7:0] s);
		cmp_count++;
		if (s !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, s);
		end
	endtask

	task automatic report_and_stop();
		if (error_cnt == 0 && cmp_count > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// one strobe cycle; the slave never stalls
	task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
		@(posedge core_clk_i);
		wr_i <= w;
		rd_i <= !w;
		addr_i <= a;
		wdata_i <= d;
		@(posedge core_clk_i);
		wr_i <= 1'h0;
		rd_i <= 1'h0;
	endtask

	task automatic rd(logic [3:0] a, logic [7:0] e);
		exp_q.push_back(e);
		bus(1'h0, a, 8'h00);
	endtask

	// let an output settle, then look at it away from the clock edge
	task automatic settle();
		repeat (2) @(negedge core_clk_i);
	endtask

	// bounded wait for either stop pulse
	task automatic wait_stop();
		for (n = 0; n < 40 && !(stop_now_o | stop_decel_o); n++)
			@(negedge core_clk_i);
		if (n == 40) begin
			chk8("stop wait", 8'h01, 8'h00);
			report_and_stop();
		end
	endtask

	// read data stand only in the cycle after the strobe
	always @(posedge core_clk_i) rd_d <= rd_i;
	always @(negedge core_clk_i)
		if (rd_d === 1'h1) chk8("rdata", exp_q.pop_front(), rdata_o);

	initial begin
		{rst_i, wr_i, rd_i, overload_i, motion_done_i, pol, hit} = 7'h40;
		{func_signal_i, addr_i, wdata_i, mir} = 21'h100000;
		error_cnt = 0;
		cmp_count = 0;
		n = $urandom(32'he9a401a0);
		repeat (4) @(posedge core_clk_i);
		rst_i <= 1'h0;
		rd(ADDR_OL_TIME, OL_TIME_RST);
		rd(ADDR_OT_CTRL, 8'h00);
		foreach (olv[i]) begin
			bus(1'h1, ADDR_OL_TIME, olv[i]);
			rd(ADDR_OL_TIME, ole[i]);
		end
		// stored 5 must not act before power-on: 50 ticks still apply
		bus(1'h1, ADDR_IRQ_MASK, 8'h07);
		overload_i <= 1'h1;
		repeat (185) @(posedge core_clk_i);
		rd(ADDR_ALARM, ALARM_NONE);
		repeat (30) @(posedge core_clk_i);
		rd(ADDR_ALARM, ALARM_OVERLOAD);
		settle();
		chk8("irq", 8'h01, {7'h00, irq_o});
		@(posedge core_clk_i);
		overload_i <= 1'h0;
		bus(1'h1, ADDR_IRQ_MASK, 8'h00);
		settle();
		chk8("irq", 8'h00, {7'h00, irq_o});
		bus(1'h1, ADDR_IRQ_STAT, 8'h07);
		bus(1'h1, ADDR_ALARM, 8'h00);
		rd(ADDR_ALARM, ALARM_NONE);
		bus(1'h1, ADDR_IRQ_MASK, 8'h07);
		settle();
		chk8("irq", 8'h00, {7'h00, irq_o});
		// random port levels, then a function takes port 3
		for (int x = 0; x < 8; x++) begin
			mir[x] = 1'($urandom());
			bus(1'h1, ADDR_OUT_DRIVE, {4'h0, mir[x], x[2:0]});
		end
		rd(ADDR_OUT_MON, mir);
		bus(1'h1, ADDR_ASSIGN, 8'h0B);
		bus(1'h1, ADDR_OUT_DRIVE, {4'h0, !mir[3], 3'h3});
		rd(ADDR_OUT_MON, mir & 8'hF7);
		settle();
		chk8("ports", mir | 8'h08, output_port_drive_o);
		@(posedge core_clk_i);
		func_signal_i <= 1'h0;
		settle();
		chk8("ports", mir & 8'hF7, output_port_drive_o);
		// releasing the function shows the level kept before it
		bus(1'h1, ADDR_ASSIGN, 8'h03);
		rd(ADDR_OUT_MON, mir);
		// positive overtravel per contact type and stop action
		for (int p = 0; p < 2; p++) begin
			bus(1'h1, ADDR_OT_CTRL, {6'h00, p[0], p[0]});
			pol <= p[0];
			bus(1'h1, ADDR_MOTION, 8'h01);
			hit <= 1'h1;
			wait_stop();
			chk8("stop", {6'h00, p[0], !p[0]},
				{6'h00, stop_decel_o, stop_now_o});
			bus(1'h1, ADDR_MOTION, 8'h01);
			rd(ADDR_MOTION, 8'h08);
			bus(1'h1, ADDR_MOTION, p ? 8'h03 : 8'h02);
			settle();
			chk8("move", p ? 8'h04 : 8'h0A, {4'h0, start_speed_o & !p[0],
				home_seek_o, motion_dir_o});
			@(posedge core_clk_i);
			hit <= 1'h0;
			if (p == 0) begin
				wait_stop();
				chk8("escape", 8'h02, {6'h00, stop_decel_o, stop_now_o});
			end
			@(posedge core_clk_i);
			motion_done_i <= 1'h1;
			@(posedge core_clk_i);
			motion_done_i <= 1'h0;
			bus(1'h1, ADDR_MOTION, 8'h04);
		end
		repeat (3) @(posedge core_clk_i);
		report_and_stop();
	end
endmodule // tb_mpo_protect_top
